// >>> pkg/rsw_regs.svh
`ifndef RSW_REGS_SVH
`define RSW_REGS_SVH

// Indexed configuration space: index port and data port.
`define RSW_IO_INDEX_PORT 8'h22
`define RSW_IO_DATA_PORT 8'h23

// Register indexes.
`define RSW_IDX_PREV_WAIT 8'h26
`define RSW_IDX_TIMING 8'h27
`define RSW_IDX_WAIT 8'h28

// Timing control register fields.
`define RSW_BIT_EARLY 5
`define RSW_BIT_FAST 4
`define RSW_BIT_WSEL 3
`define RSW_WIDTH_HI 2
`define RSW_WIDTH_LO 1

// Wait count register fields.
`define RSW_BURST_HI 4
`define RSW_BURST_LO 3
`define RSW_NBURST_HI 2
`define RSW_NBURST_LO 0

// Strap width encodings.
`define RSW_WIDTH_8_MSB 1'b0
`define RSW_WIDTH_16 2'h2
`define RSW_WIDTH_32 2'h3

// Reset values.
`define RSW_CTRL_RST 1'b0
`define RSW_BURST_RST 2'h0
`define RSW_NBURST_RST 3'h0
`define RSW_WIDTH_RST 2'h0

// Clock edges after reset release before the strap is captured.
`define RSW_STRAP_SETTLE 2'h2

`endif

// >>> pkg/rsw_pkg.sv
package rsw_pkg;
	typedef logic [1:0] rsw_width_t;
	typedef logic [1:0] rsw_burst_cnt_t;
	typedef logic [2:0] rsw_nburst_cnt_t;
	typedef logic [7:0] rsw_byte_t;
	typedef enum logic [1:0] {
		RSW_IDLE,
		RSW_WAIT,
		RSW_DONE
	} rsw_state_e;
endpackage

// >>> pkg/rsw_cfg_if.sv
`timescale 1ns/1ps
`default_nettype none
interface rsw_cfg_if;
	import rsw_pkg::*;
	logic early_select_en;
	logic fast_timing_en;
	logic fast_eff;
	logic burst_wait_sel;
	rsw_burst_cnt_t burst_wait_count;
	rsw_nburst_cnt_t nonburst_wait_count;
	rsw_width_t strap_bus_width;
	modport src (
		output early_select_en, fast_timing_en, fast_eff, burst_wait_sel,
		output burst_wait_count, nonburst_wait_count,
		input strap_bus_width
	);
	modport snk (
		input early_select_en, fast_timing_en, fast_eff, burst_wait_sel,
		input burst_wait_count, nonburst_wait_count, strap_bus_width
	);
endinterface
`default_nettype wire

// >>> src/rsw_cfg_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "rsw_regs.svh"
module rsw_cfg_regs (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic wr_timing_i,
	input wire logic wr_wait_i,
	input wire logic wr_prev_i,
	input wire rsw_pkg::rsw_byte_t wdata_i,
	output rsw_pkg::rsw_byte_t timing_rd_o,
	output rsw_pkg::rsw_byte_t wait_rd_o,
	output rsw_pkg::rsw_byte_t prev_rd_o,
	output rsw_pkg::rsw_nburst_cnt_t prev_nonburst_wait_count_o,
	output rsw_pkg::rsw_burst_cnt_t prev_burst_wait_count_o,
	rsw_cfg_if.src cfg
);
	import rsw_pkg::*;

	logic early_r;
	logic fast_r;
	logic wsel_r;
	rsw_burst_cnt_t burst_r;
	rsw_nburst_cnt_t nburst_r;
	rsw_burst_cnt_t prev_burst_r;
	rsw_nburst_cnt_t prev_nburst_r;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			early_r <= `RSW_CTRL_RST;
			fast_r <= `RSW_CTRL_RST;
			wsel_r <= `RSW_CTRL_RST;
		end else if (wr_timing_i) begin
			early_r <= wdata_i[`RSW_BIT_EARLY];
			fast_r <= wdata_i[`RSW_BIT_FAST];
			wsel_r <= wdata_i[`RSW_BIT_WSEL];
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			burst_r <= `RSW_BURST_RST;
			nburst_r <= `RSW_NBURST_RST;
		end else if (wr_wait_i) begin
			burst_r <= wdata_i[`RSW_BURST_HI:`RSW_BURST_LO];
			nburst_r <= wdata_i[`RSW_NBURST_HI:`RSW_NBURST_LO];
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			prev_burst_r <= `RSW_BURST_RST;
			prev_nburst_r <= `RSW_NBURST_RST;
		end else if (wr_prev_i) begin
			prev_burst_r <= wdata_i[`RSW_BURST_HI:`RSW_BURST_LO];
			prev_nburst_r <= wdata_i[`RSW_NBURST_HI:`RSW_NBURST_LO];
		end
	end

	assign cfg.early_select_en = early_r;
	assign cfg.fast_timing_en = fast_r;
	assign cfg.fast_eff = fast_r | (cfg.strap_bus_width == `RSW_WIDTH_32);
	assign cfg.burst_wait_sel = wsel_r;
	assign cfg.burst_wait_count = burst_r;
	assign cfg.nonburst_wait_count = nburst_r;
	assign prev_nonburst_wait_count_o = prev_nburst_r;
	assign prev_burst_wait_count_o = prev_burst_r;

	// Width bits read the strap; reserved bits read as zero.
	assign timing_rd_o = {2'h0, early_r, fast_r, wsel_r, cfg.strap_bus_width, 1'b0};
	assign wait_rd_o = {3'h0, burst_r, nburst_r};
	assign prev_rd_o = {3'h0, prev_burst_r, prev_nburst_r};
endmodule
`default_nettype wire

// >>> src/rsw_wait_gen.sv
`timescale 1ns/1ps
`default_nettype none
module rsw_wait_gen (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic rom_cyc_i,
	input wire logic burst_ok_i,
	input wire logic [3:0] low_system_addr_i,
	input wire logic iochrdy_sync_i,
	output logic rom_ready_o,
	output logic burst_follow_o,
	rsw_cfg_if.snk cfg
);
	import rsw_pkg::*;

	rsw_state_e state_r;
	logic cyc_r;
	logic fast_r;
	logic burst_r;
	logic follow_r;
	logic [3:0] addr_r;
	logic [2:0] cnt_r;
	logic [3:0] waited_r;
	logic start;
	logic next_beat;

	assign start = rom_cyc_i && !cyc_r;
	// A burst beat after the first begins when the low address bits change.
	assign next_beat = (state_r == RSW_DONE) && rom_cyc_i && burst_r &&
		(low_system_addr_i != addr_r);
	assign rom_ready_o = (state_r == RSW_WAIT) &&
		(fast_r ? (cnt_r == 3'h0) : iochrdy_sync_i);
	assign burst_follow_o = follow_r;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cyc_r <= 1'b0;
			addr_r <= 4'h0;
		end else begin
			cyc_r <= rom_cyc_i;
			addr_r <= low_system_addr_i;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_r <= RSW_IDLE;
			fast_r <= 1'b0;
			burst_r <= 1'b0;
			follow_r <= 1'b0;
			cnt_r <= 3'h0;
		end else begin
			case (state_r)
				RSW_IDLE: begin
					if (start) begin
						state_r <= RSW_WAIT;
						fast_r <= cfg.fast_eff;
						burst_r <= burst_ok_i;
						follow_r <= 1'b0;
						cnt_r <= cfg.nonburst_wait_count;
					end
				end
				RSW_WAIT: begin
					if (rom_ready_o) begin
						state_r <= RSW_DONE;
					end else if (fast_r) begin
						cnt_r <= cnt_r - 3'h1;
					end
				end
				RSW_DONE: begin
					if (!rom_cyc_i) begin
						state_r <= RSW_IDLE;
						burst_r <= 1'b0;
						follow_r <= 1'b0;
					end else if (next_beat) begin
						state_r <= RSW_WAIT;
						follow_r <= 1'b1;
						cnt_r <= {1'b0, cfg.burst_wait_count};
					end
				end
				default: begin
					state_r <= RSW_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			waited_r <= 4'h0;
		end else if (state_r != RSW_WAIT || rom_ready_o) begin
			waited_r <= 4'h0;
		end else begin
			waited_r <= waited_r + 4'h1;
		end
	end

	chk_nonburst_wait_len: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(rom_ready_o && fast_r && !follow_r) |-> (waited_r == {1'b0, $past(cfg.nonburst_wait_count, 1)})
		or $changed(cfg.nonburst_wait_count))
		else $error("Non-burst access wait length differs from programmed count.");

	chk_burst_wait_len: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(rom_ready_o && follow_r && !$changed(cfg.burst_wait_count)) |->
		(waited_r == {2'h0, cfg.burst_wait_count}))
		else $error("Burst beat wait length differs from programmed count.");

	chk_normal_ready: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(state_r == RSW_WAIT && !fast_r && !iochrdy_sync_i) |-> !rom_ready_o ##1 state_r == RSW_WAIT)
		else $error("Normal-speed access ended while the ready pin was low.");
endmodule
`default_nettype wire

// >>> src/rsw_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "rsw_regs.svh"
module rsw_top (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [7:0] io_addr_i,
	input wire logic io_wr_i,
	input wire logic io_rd_i,
	input wire rsw_pkg::rsw_byte_t io_wdata_i,
	output rsw_pkg::rsw_byte_t io_rdata_o,
	output logic io_rdata_valid_o,
	input wire rsw_pkg::rsw_width_t strap_bus_width_i,
	input wire logic addr_hit_i,
	input wire logic rom_cmd_i,
	input wire logic rom_cyc_i,
	input wire logic burst_req_i,
	input wire logic cache_en_i,
	input wire logic [3:0] low_system_addr_i,
	input wire logic iochrdy_i,
	input wire logic chan0_access_i,
	input wire rsw_pkg::rsw_width_t chan0_width_i,
	output logic rom_select_two_n_o,
	output logic rom_ready_o,
	output logic burst_timing_o,
	output logic fast_mode_o,
	output logic wide_rom_output_en_o,
	output rsw_pkg::rsw_nburst_cnt_t prev_nonburst_wait_count_o,
	output rsw_pkg::rsw_burst_cnt_t prev_burst_wait_count_o
);
	import rsw_pkg::*;

	rsw_cfg_if cfg ();

	rsw_byte_t index_r;
	rsw_byte_t timing_rd;
	rsw_byte_t wait_rd;
	rsw_byte_t prev_rd;
	rsw_width_t width_r;
	logic [1:0] settle_r;
	logic strap_done_r;
	logic [2:0] pin_meta_r;
	logic [2:0] pin_sync_r;
	logic [2:0] pin_raw;
	logic data_wr;
	logic data_rd;
	logic wr_timing;
	logic wr_wait;
	logic wr_prev;
	logic sel_fast_r;
	logic sel_act;
	logic burst_ok;
	logic burst_follow;
	logic width_burst_ok;
	logic cfg_written_r;

	// Pins from outside the clock domain pass two flip-flops per bit.
	assign pin_raw = {strap_bus_width_i, iochrdy_i};
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_sync
			always_ff @(posedge clk_i or negedge rst_n_i) begin
				if (!rst_n_i) begin
					pin_meta_r[gi] <= 1'b0;
					pin_sync_r[gi] <= 1'b0;
				end else begin
					pin_meta_r[gi] <= pin_raw[gi];
					pin_sync_r[gi] <= pin_meta_r[gi];
				end
			end
		end
	endgenerate

	// The strap is captured once, when the synchroniser has settled after reset.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			settle_r <= 2'h0;
			strap_done_r <= 1'b0;
			width_r <= `RSW_WIDTH_RST;
		end else if (!strap_done_r) begin
			if (settle_r == `RSW_STRAP_SETTLE) begin
				width_r <= pin_sync_r[2:1];
				strap_done_r <= 1'b1;
			end else begin
				settle_r <= settle_r + 2'h1;
			end
		end
	end
	assign cfg.strap_bus_width = width_r;

	// Index port holds the register number; the data port reaches the register.
	assign data_wr = io_wr_i && (io_addr_i == `RSW_IO_DATA_PORT);
	assign data_rd = io_rd_i && (io_addr_i == `RSW_IO_DATA_PORT);
	assign wr_timing = data_wr && (index_r == `RSW_IDX_TIMING);
	assign wr_wait = data_wr && (index_r == `RSW_IDX_WAIT);
	assign wr_prev = data_wr && (index_r == `RSW_IDX_PREV_WAIT);

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			index_r <= 8'h00;
		end else if (io_wr_i && io_addr_i == `RSW_IO_INDEX_PORT) begin
			index_r <= io_wdata_i;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			io_rdata_o <= 8'h00;
			io_rdata_valid_o <= 1'b0;
		end else begin
			io_rdata_valid_o <= 1'b0;
			if (io_rd_i && io_addr_i == `RSW_IO_INDEX_PORT) begin
				io_rdata_o <= index_r;
				io_rdata_valid_o <= 1'b1;
			end else if (data_rd) begin
				io_rdata_valid_o <= 1'b1;
				case (index_r)
					`RSW_IDX_TIMING: begin
						io_rdata_o <= timing_rd;
					end
					`RSW_IDX_WAIT: begin
						io_rdata_o <= wait_rd;
					end
					`RSW_IDX_PREV_WAIT: begin
						io_rdata_o <= prev_rd;
					end
					default: begin
						io_rdata_o <= 8'h00;
						io_rdata_valid_o <= 1'b0;
					end
				endcase
			end
		end
	end

	rsw_cfg_regs u_regs (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.wr_timing_i(wr_timing),
		.wr_wait_i(wr_wait),
		.wr_prev_i(wr_prev),
		.wdata_i(io_wdata_i),
		.timing_rd_o(timing_rd),
		.wait_rd_o(wait_rd),
		.prev_rd_o(prev_rd),
		.prev_nonburst_wait_count_o(prev_nonburst_wait_count_o),
		.prev_burst_wait_count_o(prev_burst_wait_count_o),
		.cfg(cfg)
	);

	// Fast mode without early select aligns the select to the clock edge.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sel_fast_r <= 1'b0;
		end else begin
			sel_fast_r <= addr_hit_i;
		end
	end

	always_comb begin
		if (cfg.early_select_en) begin
			sel_act = addr_hit_i;
		end else if (cfg.fast_eff) begin
			sel_act = sel_fast_r;
		end else begin
			sel_act = addr_hit_i && rom_cmd_i;
		end
	end
	assign rom_select_two_n_o = !sel_act;

	// Width decides burst capability; 16-bit relies on the fast bit below.
	assign width_burst_ok = (width_r[1] != `RSW_WIDTH_8_MSB);
	assign burst_ok = cfg.burst_wait_sel && burst_req_i && cache_en_i && cfg.fast_eff &&
		width_burst_ok;

	rsw_wait_gen u_wait (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.rom_cyc_i(rom_cyc_i),
		.burst_ok_i(burst_ok),
		.low_system_addr_i(low_system_addr_i),
		.iochrdy_sync_i(pin_sync_r[0]),
		.rom_ready_o(rom_ready_o),
		.burst_follow_o(burst_follow),
		.cfg(cfg)
	);

	assign burst_timing_o = burst_follow;
	assign fast_mode_o = cfg.fast_eff;
	assign wide_rom_output_en_o = chan0_access_i && (chan0_width_i == `RSW_WIDTH_32);

	chk_early_select: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		cfg.early_select_en |-> (rom_select_two_n_o == !addr_hit_i))
		else $error("Early select does not follow the raw address decode.");

	chk_normal_cmd: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(!cfg.early_select_en && !cfg.fast_eff && !rom_cmd_i) |-> rom_select_two_n_o)
		else $error("Normal-speed select asserted without the ROM command.");

	chk_fast_aligned: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(!cfg.early_select_en && cfg.fast_eff) |-> (!rom_select_two_n_o == $past(addr_hit_i)))
		else $error("Fast-mode select not aligned to the previous clock decode.");

	chk_force_fast: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(width_r == `RSW_WIDTH_32) |-> fast_mode_o)
		else $error("A 32-bit channel left fast mode.");

	chk_burst_gate: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		$rose(burst_timing_o) |-> $past(cfg.fast_eff, 1) || $past(cfg.fast_eff, 2))
		else $error("Burst timing used outside fast mode.");

	chk_narrow_burst: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(width_r[1] == `RSW_WIDTH_8_MSB && !rom_cyc_i) |=> !burst_timing_o [*2])
		else $error("An 8-bit channel entered burst timing.");

	chk_wide_oe: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		wide_rom_output_en_o |-> chan0_access_i && chan0_width_i == `RSW_WIDTH_32)
		else $error("Wide output enable driven outside channel zero 32-bit access.");

	// Remembers whether this channel's registers were written since reset.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cfg_written_r <= 1'b0;
		end else if (wr_timing || wr_wait) begin
			cfg_written_r <= 1'b1;
		end
	end

	chk_reset_zero: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		!cfg_written_r |-> (timing_rd[`RSW_BIT_EARLY:`RSW_BIT_WSEL] == 3'h0 && wait_rd == 8'h00))
		else $error("Control bits or wait counts are not zero after reset.");

	chk_width_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		strap_done_r |=> $stable(width_r))
		else $error("Latched width changed after capture.");

	chk_strap_wait: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		!strap_done_r |-> (width_r == `RSW_WIDTH_RST))
		else $error("Width changed before the strap was captured.");

	chk_timing_read: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		($past(data_rd) && $past(index_r) == `RSW_IDX_TIMING) |->
		(io_rdata_o[`RSW_WIDTH_HI:`RSW_WIDTH_LO] == $past(width_r)))
		else $error("Width field read back differs from the latched strap.");

	chk_normal_slow: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(!cfg.fast_timing_en && width_r != `RSW_WIDTH_32) |-> !fast_mode_o)
		else $error("Fast mode active with the fast bit clear on a narrow channel.");

	chk_wsel_ignored: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		!cfg.fast_eff |-> !burst_ok)
		else $error("Wait-select enabled bursts outside fast mode.");

	chk_sixteen_burst: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(width_r == `RSW_WIDTH_16 && !cfg.fast_timing_en) |-> !burst_ok)
		else $error("A 16-bit channel became burst capable without the fast bit.");

	chk_burst_needs: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		burst_ok |-> (cfg.burst_wait_sel && burst_req_i && cache_en_i))
		else $error("Burst eligibility without wait-select, burst request and caching.");

	chk_follow_start: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		$rose(burst_timing_o) |->
		($past(rom_cyc_i) && $past(low_system_addr_i, 1) != $past(low_system_addr_i, 2)))
		else $error("Burst beat started without a low address change.");

	chk_timing_write: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		$past(wr_timing) |-> (timing_rd[`RSW_BIT_EARLY:`RSW_BIT_WSEL] ==
		$past(io_wdata_i[`RSW_BIT_EARLY:`RSW_BIT_WSEL])))
		else $error("Timing control write did not land.");

	chk_wait_write: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		$past(wr_wait) |-> (wait_rd[`RSW_BURST_HI:`RSW_NBURST_LO] ==
		$past(io_wdata_i[`RSW_BURST_HI:`RSW_NBURST_LO])))
		else $error("Wait count write did not land.");

	chk_prev_write: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		$past(wr_prev) |-> (prev_nonburst_wait_count_o ==
		$past(io_wdata_i[`RSW_NBURST_HI:`RSW_NBURST_LO])))
		else $error("Preceding channel wait count write did not land.");

	chk_sel_idle: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(!addr_hit_i && !$past(addr_hit_i)) |-> rom_select_two_n_o)
		else $error("Select asserted with no address decode.");

	chk_ready_pulse: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		rom_ready_o |=> !rom_ready_o)
		else $error("Ready stood longer than one cycle.");
endmodule
`default_nettype wire

// >>> test/rsw_rom_model.sv
`timescale 1ns/1ps
`default_nettype none
module rsw_rom_model (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic rom_select_two_n_i,
	input wire logic [3:0] wait_edges_i,
	output logic iochrdy_o
);
	logic [3:0] cnt_r;
	// The ready line is pulled up, so it reads high once the device lets go of it.
	assign iochrdy_o = (!rom_select_two_n_i && cnt_r < wait_edges_i) ? 1'b0 : 1'b1;
	// Counts clock edges since select so a slow device can stretch the cycle.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_r <= 4'h0;
		end else if (rom_select_two_n_i) begin
			cnt_r <= 4'h0;
		end else if (cnt_r < wait_edges_i) begin
			cnt_r <= cnt_r + 4'h1;
		end
	end
endmodule
`default_nettype wire

// >>> test/rsw_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
module rsw_top_bench;
	import rsw_pkg::*;
	localparam int D = 5;
	logic clk = 1'b0, rst_n = 1'b0, io_wr = 1'b0, io_rd = 1'b0, addr_hit = 1'b0, rom_cmd = 1'b0;
	logic rom_cyc = 1'b0, burst_req = 1'b0, cache_en = 1'b0, chan0_acc = 1'b0;
	logic iochrdy, sel_n, rdy, burst, fast, wide, rvalid;
	logic [7:0] io_addr = 8'h00;
	logic [3:0] low_addr = 4'h0, wait_edges = 4'h0;
	rsw_byte_t io_wdata = 8'h00, rdata;
	rsw_width_t strap = 2'h0, chan0_w = 2'h0;
	rsw_nburst_cnt_t prev_nb;
	rsw_burst_cnt_t prev_b;
	int errors = 0, n_checks = 0;

	rsw_top u_rsw_top (.clk_i(clk), .rst_n_i(rst_n), .io_addr_i(io_addr), .io_wr_i(io_wr),
		.io_rd_i(io_rd), .io_wdata_i(io_wdata), .io_rdata_o(rdata), .io_rdata_valid_o(rvalid),
		.strap_bus_width_i(strap), .addr_hit_i(addr_hit), .rom_cmd_i(rom_cmd),
		.rom_cyc_i(rom_cyc), .burst_req_i(burst_req), .cache_en_i(cache_en),
		.low_system_addr_i(low_addr), .iochrdy_i(iochrdy), .chan0_access_i(chan0_acc),
		.chan0_width_i(chan0_w), .rom_select_two_n_o(sel_n), .rom_ready_o(rdy),
		.burst_timing_o(burst), .fast_mode_o(fast), .wide_rom_output_en_o(wide),
		.prev_nonburst_wait_count_o(prev_nb), .prev_burst_wait_count_o(prev_b));
	rsw_rom_model u_rsw_rom_model (.clk_i(clk), .rst_n_i(rst_n), .rom_select_two_n_i(sel_n),
		.wait_edges_i(wait_edges), .iochrdy_o(iochrdy));

	initial begin
		forever #25 clk = ~clk;
	end

	task automatic give_verdict();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic check_bits(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic check_cyc(input string what, input int exp, input int got);
		n_checks++;
		if (got != exp) begin
			errors++;
			$display("mismatch %s expected %0d seen %0d", what, exp, got);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#D;
	endtask

	task automatic io_put(input logic [7:0] a, input logic [7:0] d);
		io_addr = a;
		io_wdata = d;
		io_wr = 1'b1;
		tick(1);
		io_wr = 1'b0;
		tick(1);
	endtask

	task automatic reg_wr(input logic [7:0] idx, input logic [7:0] d);
		io_put(8'h22, idx);
		io_put(8'h23, d);
	endtask

	task automatic reg_rd(input logic [7:0] idx, input logic [7:0] exp, input logic vexp);
		io_put(8'h22, idx);
		io_addr = 8'h23;
		io_rd = 1'b1;
		tick(1);
		io_rd = 1'b0;
		check_bits("read data", exp, rdata);
		check_bits("read valid", {7'h0, vexp}, {7'h0, rvalid});
		tick(1);
	endtask

	task automatic sel_check(input logic hit, input logic cmd, input logic exp);
		addr_hit = hit;
		rom_cmd = cmd;
		#1;
		check_bits("select", {7'h0, exp}, {7'h0, sel_n});
		tick(1);
	endtask

	task automatic wait_ready(output int k);
		k = 0;
		do begin
			tick(1);
			k++;
		end while (rdy !== 1'b1 && k < 40);
	endtask

	// Burst beats start with a change of the low address bits; other accesses restart the cycle.
	task automatic rom_access(input int first, input int later, input int beats, input logic exp_b);
		int k;
		low_addr = 4'h0;
		rom_cyc = 1'b1;
		wait_ready(k);
		check_cyc("first beat", first, k);
		check_bits("first beat timing", 8'h00, {7'h0, burst});
		for (int b = 1; b < beats; b++) begin
			tick(1);
			low_addr = low_addr + 4'h4;
			if (!exp_b) begin
				rom_cyc = 1'b0;
				tick(1);
				rom_cyc = 1'b1;
			end
			wait_ready(k);
			check_cyc("later beat", later, k);
			check_bits("later beat timing", {7'h0, exp_b}, {7'h0, burst});
		end
		tick(1);
		rom_cyc = 1'b0;
		tick(2);
	endtask

	task automatic do_reset(input rsw_width_t s);
		strap = s;
		rst_n = 1'b0;
		tick(10);
		rst_n = 1'b1;
		tick(8);
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		errors++;
		give_verdict();
	end

	initial begin
		burst_req = 1'b1;
		cache_en = 1'b1;
		for (int s = 0; s < 4; s++) begin
			do_reset(2'(s));
			reg_rd(8'h27, {5'h0, 2'(s), 1'b0}, 1'b1);
			reg_rd(8'h28, 8'h00, 1'b1);
			check_bits("fast mode", {7'h0, s == 3}, {7'h0, fast});
			reg_wr(8'h27, 8'h18);
			reg_wr(8'h28, 8'h0B);
			rom_access(4, s > 1 ? 2 : 4, 2, s > 1);
		end
		reg_wr(8'h27, 8'h08);
		check_bits("fast mode", 8'h01, {7'h0, fast});
		rom_access(4, 2, 4, 1'b1);
		for (int i = 0; i < 8; i++) begin
			{chan0_acc, chan0_w} = 3'(i);
			tick(1);
			check_bits("wide enable", {7'h0, i == 7}, {7'h0, wide});
		end
		burst_req = 1'b0;
		reg_wr(8'h27, 8'h10);
		for (int n = 0; n < 8; n++) begin
			reg_wr(8'h28, 8'(n));
			rom_access(n + 1, 0, 1, 1'b0);
		end
		burst_req = 1'b1;
		reg_wr(8'h27, 8'h18);
		for (int b = 0; b < 4; b++) begin
			reg_wr(8'h28, {3'h0, 2'(b), 3'h3});
			rom_access(4, b + 1, 4, 1'b1);
		end
		reg_wr(8'h28, 8'h0B);
		cache_en = 1'b0;
		rom_access(4, 4, 2, 1'b0);
		cache_en = 1'b1;
		burst_req = 1'b0;
		rom_access(4, 4, 2, 1'b0);
		burst_req = 1'b1;
		reg_wr(8'h27, 8'h10);
		rom_access(4, 4, 2, 1'b0);
		reg_wr(8'h26, 8'h17);
		check_bits("prev counts", 8'h17, {3'h0, prev_b, prev_nb});
		reg_rd(8'h26, 8'h17, 1'b1);
		reg_wr(8'h27, 8'h38);
		reg_rd(8'h27, 8'h3E, 1'b1);
		reg_rd(8'h40, 8'h00, 1'b0);
		do_reset(2'h2);
		reg_wr(8'h27, 8'h20);
		sel_check(1'b1, 1'b0, 1'b0);
		sel_check(1'b0, 1'b1, 1'b1);
		reg_wr(8'h27, 8'h00);
		sel_check(1'b1, 1'b0, 1'b1);
		sel_check(1'b1, 1'b1, 1'b0);
		sel_check(1'b0, 1'b0, 1'b1);
		reg_wr(8'h27, 8'h10);
		sel_check(1'b1, 1'b0, 1'b1);
		sel_check(1'b1, 1'b0, 1'b0);
		sel_check(1'b0, 1'b0, 1'b0);
		sel_check(1'b0, 1'b0, 1'b1);
		reg_wr(8'h28, 8'h1F);
		reg_wr(8'h27, 8'h08);
		check_bits("fast mode", 8'h00, {7'h0, fast});
		for (int w = 0; w < 7; w += 6) begin
			wait_edges = 4'(w);
			addr_hit = 1'b1;
			rom_cmd = 1'b1;
			tick(3);
			rom_access(w == 0 ? 1 : w - 1, 0, 1, 1'b0);
			addr_hit = 1'b0;
			rom_cmd = 1'b0;
			tick(1);
		end
		give_verdict();
	end
endmodule
`default_nettype wire
